// ---- logic/dacc_controller.sv ----
`timescale 1ns/1ps
// Summary of operation
// RL1 - Emit empty event when buffer empties, only while empty event output enabled.
// RL2 - Enabled start event moves buffer into data when ready, starting conversion; resynchronized.
// RL3 - Any of several start event sources triggers the start action.
// RL4 - Start edge is rising by default, falling when inversion bit set.
// RL5 - In standby keep output if keep bit set, else disable output buffer.
// RL6 - Synchronized write sets busy bit at once, clears after synchronization.
// RL7 - Synchronized write while its busy bit set is discarded with an error.
// RL8 - Soft reset, enable, data and buffer writes synchronize on busy bits 0-3.
// RL9 - Internal output enable routes code to comparator, together with external output.
// RL10 - Buffer and data registers form a two-entry FIFO advanced by start events.
// RL11 - Start event with empty buffer flags underrun and raises enabled interrupt.
// RL12 - Buffer becoming empty raises enabled empty interrupt request.
// RL13 - Pump follows low-voltage sense automatically; pump disable bit forces off.
// RL14 - Dither mode: data bits 13:4 give code, bits 3:0 dither.
// RL15 - Dither mode runs 16 sub-conversions, code or code plus one.
// RL16 - Dither mode reloads buffer every 16 starts; empty event and request follow.
// RL17 - Left aligned dither takes code from bits 15:6, dither from 5:2.
// RL18 - Byte and halfword accesses reach parts of wider registers.
// RL19 - Control B and event control accept writes only while disabled.
// RL20 - Enable bit reads back at once; takes effect after synchronization.
// RL21 - Soft reset restores registers, disables, discards other writes; writing zero ignored.
// RL22 - Reference select: 0 internal, 1 analog supply, 2 external, 3 reserved.
// RL23 - Any new value loaded into data starts a conversion; a data write landing while disabled loads without one.
// RL24 - Empty flag clears on write one or on new buffer data.
// RL25 - Discarded synchronized write answers the bus with an error.
module dacc_controller #(
    parameter int N_START_SRC = 2,
    parameter int SYNC_CYCLES = dacc_pkg::SYNC_CYCLES,
    parameter int STARTUP_CYCLES = dacc_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events and system state
    input wire logic [N_START_SRC-1:0] start_event,
    input wire logic standby,
    input wire logic debug_halt,
    input wire logic low_voltage,
    // Converter side
    output logic [9:0] dac_code,
    output logic conv_start,
    output logic external_output_en,
    output logic internal_output_en,
    output logic [1:0] reference_select,
    output logic pump_on,
    // Event, DMA and interrupt outputs
    output logic empty_event,
    output logic dma_req,
    output logic irq
);
    localparam int SUB_W = $clog2(dacc_pkg::DITHER_SUBS);
    localparam int UP_W = $clog2(STARTUP_CYCLES + 1);

    initial begin
        if (N_START_SRC < 1 || SYNC_CYCLES < 1 || STARTUP_CYCLES < 1) begin
            $error("dacc_controller: parameters must be at least 1");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] control_a_r;
    logic [7:0] control_b_r;
    logic [7:0] event_control_r;
    logic [7:0] irq_enable_r;
    logic [7:0] irq_flags_r;
    logic [15:0] sample_data_r;
    logic [15:0] sample_buffer_r;
    logic [15:0] data_pend_r;
    logic [15:0] buf_pend_r;
    logic [7:0] debug_control_r;
    logic enabled_r;
    logic buf_full_r;
    logic ready_r;
    logic [UP_W-1:0] startup_cnt_r;
    logic [SUB_W-1:0] sub_cnt_r;
    logic [N_START_SRC-1:0] ev_meta_r;
    logic [N_START_SRC-1:0] ev_sync_r;
    logic [N_START_SRC-1:0] ev_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [5:0] idx;
    logic aligned;
    logic access;
    logic wr;
    logic [dacc_pkg::SB_COUNT-1:0] sync_start;
    logic [dacc_pkg::SB_COUNT-1:0] sync_busy;
    logic [dacc_pkg::SB_COUNT-1:0] sync_done;
    logic wr_err;
    logic mapped;
    logic soft_clear;

    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access = psel && penable && !pready;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign soft_clear = sync_done[dacc_pkg::SB_SOFT_RESET];

    always_comb begin
        mapped = aligned;
        case (idx)
            dacc_pkg::IDX_CONTROL_A, dacc_pkg::IDX_CONTROL_B, dacc_pkg::IDX_EVENT_CONTROL,
            dacc_pkg::IDX_IRQ_ENABLE_CLEAR, dacc_pkg::IDX_IRQ_ENABLE_SET, dacc_pkg::IDX_IRQ_FLAGS,
            dacc_pkg::IDX_READY_STATUS, dacc_pkg::IDX_SAMPLE_DATA, dacc_pkg::IDX_SAMPLE_BUFFER,
            dacc_pkg::IDX_SYNC_BUSY_FLAGS, dacc_pkg::IDX_DEBUG_CONTROL: begin
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Error on a write whose synchronized target is still busy
    always_comb begin
        wr_err = 1'b0;
        if (pwrite) begin
            case (idx)
                dacc_pkg::IDX_CONTROL_A: begin
                    if (pstrb[0]) begin
                        if (pwdata[dacc_pkg::CA_SOFT_RESET]) begin
                            wr_err = sync_busy[dacc_pkg::SB_SOFT_RESET]; // RL7
                        end else begin
                            wr_err = sync_busy[dacc_pkg::SB_ENABLE]; // RL7
                        end
                    end
                end
                dacc_pkg::IDX_SAMPLE_DATA: wr_err = |pstrb[1:0] && sync_busy[dacc_pkg::SB_DATA]; // RL7
                dacc_pkg::IDX_SAMPLE_BUFFER: wr_err = |pstrb[1:0] && sync_busy[dacc_pkg::SB_BUFFER]; // RL7
                default: wr_err = 1'b0;
            endcase
        end
    end

    // Response one cycle into the access phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access;
            pslverr <= access && (!mapped || wr_err); // RL25
            prdata <= '0;
            if (access && !pwrite && mapped) begin
                case (idx)
                    dacc_pkg::IDX_CONTROL_A: prdata[7:0] <= control_a_r;
                    dacc_pkg::IDX_CONTROL_B: prdata[7:0] <= control_b_r;
                    dacc_pkg::IDX_EVENT_CONTROL: prdata[7:0] <= event_control_r;
                    dacc_pkg::IDX_IRQ_ENABLE_CLEAR: prdata[7:0] <= irq_enable_r;
                    dacc_pkg::IDX_IRQ_ENABLE_SET: prdata[7:0] <= irq_enable_r;
                    dacc_pkg::IDX_IRQ_FLAGS: prdata[7:0] <= irq_flags_r;
                    dacc_pkg::IDX_READY_STATUS: prdata[0] <= ready_r;
                    dacc_pkg::IDX_SAMPLE_DATA: prdata[15:0] <= sample_data_r;
                    dacc_pkg::IDX_SYNC_BUSY_FLAGS: prdata[dacc_pkg::SB_COUNT-1:0] <= sync_busy; // RL6
                    dacc_pkg::IDX_DEBUG_CONTROL: prdata[7:0] <= debug_control_r;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write synchronizers, busy bits 0..3
    always_comb begin
        sync_start = '0;
        if (wr && idx == dacc_pkg::IDX_CONTROL_A && pstrb[0]) begin
            if (pwdata[dacc_pkg::CA_SOFT_RESET]) begin
                sync_start[dacc_pkg::SB_SOFT_RESET] = 1'b1; // RL8
            end else begin
                sync_start[dacc_pkg::SB_ENABLE] = 1'b1; // RL8
            end
        end
        if (wr && idx == dacc_pkg::IDX_SAMPLE_DATA && |pstrb[1:0]) begin
            sync_start[dacc_pkg::SB_DATA] = 1'b1; // RL8
        end
        if (wr && idx == dacc_pkg::IDX_SAMPLE_BUFFER && |pstrb[1:0]) begin
            sync_start[dacc_pkg::SB_BUFFER] = 1'b1; // RL8
        end
    end

    genvar g;
    generate
        for (g = 0; g < dacc_pkg::SB_COUNT; g++) begin : g_sync
            dacc_sync_busy #(.CYCLES(SYNC_CYCLES)) u_busy ( // RL6
                .clk_sys(clk_sys),
                .reset(reset),
                .start(sync_start[g]),
                .busy(sync_busy[g]),
                .done(sync_done[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear) begin // RL21
            control_a_r <= '0;
            control_b_r <= '0;
            event_control_r <= '0;
            irq_enable_r <= '0;
            enabled_r <= 1'b0;
        end else begin
            if (sync_done[dacc_pkg::SB_ENABLE]) begin
                enabled_r <= control_a_r[dacc_pkg::CA_ENABLE]; // RL20
            end
            if (wr && pstrb[0]) begin
                case (idx)
                    dacc_pkg::IDX_CONTROL_A: begin
                        if (pwdata[dacc_pkg::CA_SOFT_RESET]) begin
                            control_a_r[dacc_pkg::CA_SOFT_RESET] <= 1'b1; // RL21
                        end else begin
                            control_a_r <= pwdata[7:0] & dacc_pkg::CA_MASK; // RL20
                        end
                    end
                    dacc_pkg::IDX_CONTROL_B: begin
                        if (!enabled_r && !control_a_r[dacc_pkg::CA_ENABLE]) begin
                            control_b_r <= pwdata[7:0] & dacc_pkg::CB_MASK; // RL19
                        end
                    end
                    dacc_pkg::IDX_EVENT_CONTROL: begin
                        if (!enabled_r && !control_a_r[dacc_pkg::CA_ENABLE]) begin
                            event_control_r <= pwdata[7:0] & dacc_pkg::EV_MASK; // RL19
                        end
                    end
                    dacc_pkg::IDX_IRQ_ENABLE_CLEAR: irq_enable_r <= irq_enable_r & ~(pwdata[7:0] & dacc_pkg::IRQ_MASK);
                    dacc_pkg::IDX_IRQ_ENABLE_SET: irq_enable_r <= irq_enable_r | (pwdata[7:0] & dacc_pkg::IRQ_MASK);
                    default: begin
                    end
                endcase
            end
        end
    end

    // Survives soft reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            debug_control_r <= '0;
        end else if (wr && pstrb[0] && idx == dacc_pkg::IDX_DEBUG_CONTROL) begin
            debug_control_r <= {7'h00, pwdata[0]};
        end
    end

    // Pending values, byte-lane merged
    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear) begin
            data_pend_r <= '0;
            buf_pend_r <= '0;
        end else if (wr) begin
            if (idx == dacc_pkg::IDX_SAMPLE_DATA) begin
                data_pend_r[7:0] <= pstrb[0] ? pwdata[7:0] : sample_data_r[7:0]; // RL18
                data_pend_r[15:8] <= pstrb[1] ? pwdata[15:8] : sample_data_r[15:8]; // RL18
            end
            if (idx == dacc_pkg::IDX_SAMPLE_BUFFER) begin
                buf_pend_r[7:0] <= pstrb[0] ? pwdata[7:0] : sample_buffer_r[7:0]; // RL18
                buf_pend_r[15:8] <= pstrb[1] ? pwdata[15:8] : sample_buffer_r[15:8]; // RL18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start event input
    logic [N_START_SRC-1:0] ev_edge;
    logic start_hit;
    logic run_ok;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ev_meta_r <= '0;
            ev_sync_r <= '0;
            ev_prev_r <= '0;
        end else begin
            ev_meta_r <= start_event; // RL2
            ev_sync_r <= ev_meta_r;
            ev_prev_r <= ev_sync_r;
        end
    end

    assign ev_edge = event_control_r[dacc_pkg::EV_INVERT] ? (ev_prev_r & ~ev_sync_r)
                                                         : (ev_sync_r & ~ev_prev_r); // RL4
    assign run_ok = enabled_r && ready_r && !(debug_halt && !debug_control_r[0]);
    assign start_hit = (|ev_edge) && event_control_r[dacc_pkg::EV_START_IN] && run_ok; // RL3

    // Startup time before ready
    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear || !enabled_r) begin
            startup_cnt_r <= '0;
            ready_r <= 1'b0;
        end else if (!ready_r) begin
            if (startup_cnt_r == UP_W'(STARTUP_CYCLES - 1)) begin
                ready_r <= 1'b1;
            end else begin
                startup_cnt_r <= startup_cnt_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry FIFO and dithering
    logic dither;
    logic need_load;
    logic load_from_buf;
    logic underrun;

    assign dither = control_b_r[dacc_pkg::CB_DITHER];
    assign need_load = !dither || sub_cnt_r == '0;
    assign load_from_buf = start_hit && need_load && buf_full_r; // RL10
    assign underrun = start_hit && need_load && !buf_full_r; // RL11

    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear) begin
            sample_data_r <= '0;
            sample_buffer_r <= '0;
            buf_full_r <= 1'b0;
            sub_cnt_r <= '0;
        end else begin
            if (sync_done[dacc_pkg::SB_BUFFER]) begin
                sample_buffer_r <= buf_pend_r;
                buf_full_r <= 1'b1;
            end else if (load_from_buf) begin
                buf_full_r <= 1'b0; // RL10
            end
            if (load_from_buf) begin
                sample_data_r <= sample_buffer_r; // RL2
            end else if (sync_done[dacc_pkg::SB_DATA]) begin
                sample_data_r <= data_pend_r; // RL23
            end
            if (load_from_buf || sync_done[dacc_pkg::SB_DATA] || !dither) begin
                sub_cnt_r <= (dither && load_from_buf) ? SUB_W'(1) : '0; // RL16
            end else if (start_hit && !need_load) begin
                sub_cnt_r <= sub_cnt_r + 1'b1; // RL15
            end
        end
    end

    // Code selection, from the word this edge loads
    logic [15:0] data_now;
    logic [9:0] base_code;
    logic [3:0] dither_bits;
    logic [SUB_W-1:0] sub_now;
    logic bump;

    assign data_now = load_from_buf ? sample_buffer_r : sync_done[dacc_pkg::SB_DATA] ? data_pend_r : sample_data_r;

    always_comb begin
        if (control_b_r[dacc_pkg::CB_LEFT_ALIGN]) begin
            base_code = data_now[dacc_pkg::LEFT_CODE_LO +: 10]; // RL17
            dither_bits = data_now[dacc_pkg::LEFT_DITHER_LO +: 4]; // RL17
        end else if (dither) begin
            base_code = data_now[dacc_pkg::RIGHT_CODE_LO +: 10]; // RL14
            dither_bits = data_now[3:0]; // RL14
        end else begin
            base_code = data_now[9:0];
            dither_bits = 4'h0;
        end
    end

    assign sub_now = sub_cnt_r;
    assign bump = dither && (sub_now < dither_bits) && (base_code != dacc_pkg::CODE_MAX); // RL15

    ////////////////////////////////////////////////////////////////////////////
    // Flags, events and outputs
    logic flag_clr_wr;
    logic new_conv;

    assign flag_clr_wr = wr && pstrb[0] && idx == dacc_pkg::IDX_IRQ_FLAGS;
    assign new_conv = start_hit && !underrun || (sync_done[dacc_pkg::SB_DATA] && enabled_r); // RL23

    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear) begin
            irq_flags_r <= '0;
        end else begin
            if (underrun) begin
                irq_flags_r[dacc_pkg::IRQ_UNDERRUN] <= 1'b1; // RL11
            end else if (flag_clr_wr && pwdata[dacc_pkg::IRQ_UNDERRUN]) begin
                irq_flags_r[dacc_pkg::IRQ_UNDERRUN] <= 1'b0;
            end
            if (load_from_buf) begin
                irq_flags_r[dacc_pkg::IRQ_EMPTY] <= 1'b1; // RL12
            end else if ((flag_clr_wr && pwdata[dacc_pkg::IRQ_EMPTY]) || sync_done[dacc_pkg::SB_BUFFER]) begin
                irq_flags_r[dacc_pkg::IRQ_EMPTY] <= 1'b0; // RL24
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || soft_clear) begin
            dac_code <= '0;
            conv_start <= 1'b0;
            empty_event <= 1'b0;
            dma_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            conv_start <= new_conv;
            if (new_conv) begin
                dac_code <= base_code + {9'h000, bump};
            end
            empty_event <= load_from_buf && event_control_r[dacc_pkg::EV_EMPTY_OUT]; // RL1
            dma_req <= enabled_r && !buf_full_r && !sync_busy[dacc_pkg::SB_BUFFER]; // RL16
            irq <= |(irq_flags_r & irq_enable_r & dacc_pkg::IRQ_MASK); // RL12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            external_output_en <= 1'b0;
            internal_output_en <= 1'b0;
            reference_select <= dacc_pkg::REF_INTERNAL;
            pump_on <= 1'b0;
        end else begin
            external_output_en <= enabled_r && control_b_r[dacc_pkg::CB_EXT_OUT]
                && !(standby && !control_a_r[dacc_pkg::CA_KEEP_STANDBY]); // RL5
            internal_output_en <= enabled_r && control_b_r[dacc_pkg::CB_INT_OUT]; // RL9
            reference_select <= control_b_r[dacc_pkg::CB_REF_LO +: 2]; // RL22
            pump_on <= enabled_r && low_voltage && !control_b_r[dacc_pkg::CB_PUMP_DISABLE]; // RL13
        end
    end
endmodule : dacc_controller

// ---- inc/dacc_pkg.sv ----
package dacc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL_A = 6'h00;
    localparam logic [5:0] IDX_CONTROL_B = 6'h01;
    localparam logic [5:0] IDX_EVENT_CONTROL = 6'h02;
    localparam logic [5:0] IDX_IRQ_ENABLE_CLEAR = 6'h04;
    localparam logic [5:0] IDX_IRQ_ENABLE_SET = 6'h05;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h06;
    localparam logic [5:0] IDX_READY_STATUS = 6'h07;
    localparam logic [5:0] IDX_SAMPLE_DATA = 6'h08;
    localparam logic [5:0] IDX_SAMPLE_BUFFER = 6'h0C;
    localparam logic [5:0] IDX_SYNC_BUSY_FLAGS = 6'h10;
    localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h18;

    // control_a fields
    localparam int CA_SOFT_RESET = 0;
    localparam int CA_ENABLE = 1;
    localparam int CA_KEEP_STANDBY = 6;
    // control_b fields
    localparam int CB_EXT_OUT = 0;
    localparam int CB_INT_OUT = 1;
    localparam int CB_LEFT_ALIGN = 2;
    localparam int CB_PUMP_DISABLE = 3;
    localparam int CB_DITHER = 5;
    localparam int CB_REF_LO = 6;
    // event_control fields
    localparam int EV_START_IN = 0;
    localparam int EV_EMPTY_OUT = 1;
    localparam int EV_INVERT = 2;
    // irq bit positions
    localparam int IRQ_UNDERRUN = 0;
    localparam int IRQ_EMPTY = 1;
    // sync_busy_flags positions
    localparam int SB_SOFT_RESET = 0;
    localparam int SB_ENABLE = 1;
    localparam int SB_DATA = 2;
    localparam int SB_BUFFER = 3;
    localparam int SB_COUNT = 4;

    // Valid-bit masks
    localparam logic [7:0] CA_MASK = 8'h43;
    localparam logic [7:0] CB_MASK = 8'hEF;
    localparam logic [7:0] EV_MASK = 8'h07;
    localparam logic [7:0] IRQ_MASK = 8'h03;

    // Reference encodings
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
    localparam logic [1:0] REF_EXTERNAL = 2'h2;

    // Dither layout
    localparam int DITHER_SUBS = 16;
    localparam int RIGHT_CODE_LO = 4;
    localparam int LEFT_CODE_LO = 6;
    localparam int LEFT_DITHER_LO = 2;
    localparam int PLAIN_LEFT_LO = 6;
    localparam logic [9:0] CODE_MAX = 10'h3FF;

    // Timing in ns, converted to cycles of the 4 ns clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_TIME_NS = 20;
    localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_TIME_NS = 400;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dacc_pkg

// ---- logic/dacc_sync_busy.sv ----
`timescale 1ns/1ps
module dacc_sync_busy #(
    parameter int CYCLES = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request
    input wire logic start,
    // Status
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("dacc_sync_busy: CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] count_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count_r <= CW'(CYCLES - 1);
            end else if (busy) begin
                if (count_r == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_r <= count_r - 1'b1;
                end
            end
        end
    end
endmodule : dacc_sync_busy

// ---- tb/dacc_controller_assertions.sv ----
`timescale 1ns/1ps
module dacc_controller_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Converter
    input wire logic low_voltage,
    input wire logic [9:0] dac_code,
    input wire logic conv_start,
    input wire logic pump_on,
    input wire logic empty_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_in_access: assert property (pready |-> s_access)
        else $error("ready outside access");
    a_access_answered: assert property (s_access ##0 !pready |-> ##[1:2] pready)
        else $error("access not answered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_empty_on_load: assert property (empty_event |-> conv_start)
        else $error("empty event without load");
    a_pump_follows: assert property (pump_on |-> $past(low_voltage))
        else $error("pump on at normal supply");
    a_code_on_conv: assert property ($changed(dac_code) |-> conv_start)
        else $error("code changed without start");
endmodule : dacc_controller_assertions
////////////////////////////////////////////////////////////////
bind dacc_controller dacc_controller_assertions i_chk (.clk_sys, .reset, .psel, .penable, .pready,
    .pslverr, .low_voltage, .dac_code, .conv_start, .pump_on, .empty_event);

// ---- tb/dacc_event_net.sv ----
`timescale 1ns/1ps
module dacc_event_net (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request from bench
    input wire logic [1:0] fire,
    // Events to converter
    output logic [1:0] start_event
);
    logic [2:0] hold_r;
    // Request becomes a level pulse long enough to resynchronize
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            start_event <= 2'h0;
            hold_r <= 3'h0;
        end else if (fire != 2'h0) begin
            start_event <= fire;
            hold_r <= 3'h6;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end else begin
            start_event <= 2'h0;
        end
    end
endmodule : dacc_event_net

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] CA = 8'h00, CB = 8'h04, EV = 8'h08, IEC = 8'h10, IES = 8'h14, IFL = 8'h18;
    localparam logic [7:0] ST = 8'h1C, DAT = 8'h20, BUF = 8'h30, SB = 8'h40;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, low_voltage, e;
    logic conv_start, empty_event, dma_req, irq, pump_on, ext_en, int_en;
    logic [7:0] paddr;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] fire, start_event, reference_select;
    logic [9:0] dac_code;
    int fail_count, samples_checked, conv_n, empty_n;
    dacc_event_net i_net (.clk_sys, .reset, .fire, .start_event);
    dacc_controller #(.STARTUP_CYCLES(3)) i_dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .start_event, .standby(1'b0),
        .debug_halt(1'b0), .low_voltage, .dac_code, .conv_start, .external_output_en(ext_en),
        .internal_output_en(int_en), .reference_select, .pump_on, .empty_event, .dma_req, .irq);
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (conv_start === 1'b1) conv_n++;
        if (empty_event === 1'b1) empty_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1, a, d);
        chk(e, ee);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
        apb(0, a, 0);
        chk(e, ee);
        chk(r, x);
    endtask : rd
    task automatic ev(input logic [1:0] f);
        fire <= f;
        @(posedge clk_sys);
        fire <= 0;
        repeat (12) @(posedge clk_sys);
    endtask : ev
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        test_done;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fire, low_voltage} = 0;
        {fail_count, samples_checked, conv_n, empty_n} = 0;
        reset = 1;
        repeat (2) @(posedge clk_sys);
        reset <= 0;
        rd(8'h0C, 0, 1);
        wr(CB, 32'h44, 0);
        rd(CB, 32'h44, 0);
        wr(CA, 1, 0);
        rd(SB, 1, 0);
        repeat (10) @(posedge clk_sys);
        rd(CB, 0, 0);
        rd(SB, 0, 0);
        $display("soft reset test done");
        low_voltage <= 1;
        for (int i = 0; i < 3; i++) begin
            wr(CB, {i[1:0], 6'h03}, 0);
            repeat (2) @(posedge clk_sys);
            chk(reference_select, i[1:0]);
            chk({ext_en, int_en, pump_on}, 3'h0);
        end
        $display("output test done");
        wr(CB, 3, 0);
        wr(EV, 7, 0);
        wr(IES, 3, 0);
        wr(CA, 2, 0);
        wr(CA, 2, 1);
        rd(CA, 2, 0);
        repeat (10) @(posedge clk_sys);
        rd(ST, 1, 0);
        chk({ext_en, int_en, pump_on}, 3'h7);
        wr(CB, 32'hFF, 0);
        rd(CB, 3, 0);
        wr(BUF, 32'h155, 0);
        repeat (8) @(posedge clk_sys);
        ev(2'h1);
        chk(conv_n, 1);
        chk(dac_code, 10'h155);
        chk(empty_n, 1);
        rd(IFL, 2, 0);
        chk(dma_req, 1);
        ev(2'h2);
        rd(IFL, 3, 0);
        chk({irq, conv_n[3:0]}, 5'h11);
        wr(IFL, 1, 0);
        wr(BUF, 32'h1, 0);
        repeat (8) @(posedge clk_sys);
        rd(IFL, 0, 0);
        chk(irq, 0);
        wr(DAT, 32'h77, 0);
        repeat (8) @(posedge clk_sys);
        chk(conv_n, 2);
        chk(dac_code, 10'h077);
        wr(CA, 0, 0);
        pstrb <= 4'h2;
        wr(DAT, 32'h3300, 0);
        pstrb <= 4'hF;
        wr(CB, 32'h0B, 0);
        wr(CA, 2, 0);
        rd(DAT, 32'h3377, 0);
        repeat (4) @(posedge clk_sys);
        chk({ext_en, int_en, pump_on}, 3'h6);
        $display("event test done");
        test_done;
    end
endmodule : tb
